// *** rtl/bms_consts.vh ***
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH

// Clock and timing
`define BMS_CLK_HZ          50000000
`define BMS_CLK_MHZ         (`BMS_CLK_HZ / 1000000)
`define BMS_MODE_READ_US    10000
`define BMS_MODE_READ_CYC   24'h07_a120
`define BMS_START_DLY_US    150000
`define BMS_START_DLY_CYC   24'h72_70e0
`define BMS_FAULT_DLY_US    100000
`define BMS_FAULT_DLY_CYC   24'h4c_4b40
`define BMS_TMR_W           24

// LLC gate timing in clock cycles
`define BMS_LLC_HALF_CYC    16'h0064
`define BMS_LLC_DEAD_CYC    16'h000a
`define BMS_LLC_CNT_W       16

// Register offsets
`define BMS_OFF_CONTROL     12'h000
`define BMS_OFF_STATUS      12'h004

// Control fields and reset value
`define BMS_CTL_RUN_ALLOW   0
`define BMS_CTL_RESET       1'b1

// Status fields
`define BMS_ST_STATE_LSB    0
`define BMS_ST_SELF_BIAS    4
`define BMS_ST_DECIDED      5
`define BMS_ST_PFC_ON       6
`define BMS_ST_LLC_ON       7
`define BMS_ST_FET_ON       8
`define BMS_ST_UV_SEEN      9

// Flag vector positions
`define BMS_F_VCC_START     0
`define BMS_F_SELF_BIAS_START_LEVEL  1
`define BMS_F_SELF_BIAS_STOP_LEVEL   2
`define BMS_F_VCC_AB_STOP   3
`define BMS_F_MODE_SELECT   4
`define BMS_F_PFC_RUN       5
`define BMS_F_COMB_RUN      6
`define BMS_F_MODE_RAIL     7
`define BMS_F_LINE_CUR      8
`define BMS_F_BUS_OK        9
`define BMS_NFLAG           10

// AXI responses
`define BMS_RESP_OKAY       2'b00
`define BMS_RESP_SLVERR     2'b10

`endif

// *** rtl/bms_gate_gen.v ***
`include "bms_consts.vh"
`default_nettype none

module bms_gate_gen #(
  parameter [`BMS_LLC_CNT_W-1:0] HALF_CYC = `BMS_LLC_HALF_CYC,
  parameter [`BMS_LLC_CNT_W-1:0] DEAD_CYC = `BMS_LLC_DEAD_CYC
) (
  // Clock and reset
  input  wire aclk,
  input  wire aresetn,
  // Burst request
  input  wire enable,
  // Gate outputs and burst busy flag
  output reg  gate_a,
  output reg  gate_b,
  output wire busy
);

  localparam [`BMS_LLC_CNT_W-1:0] PERIOD   = HALF_CYC + HALF_CYC;
  localparam [`BMS_LLC_CNT_W-1:0] ON_CYC   = HALF_CYC - DEAD_CYC;
  localparam [`BMS_LLC_CNT_W-1:0] A_HALF   = HALF_CYC - (ON_CYC >> 1);
  localparam [`BMS_LLC_CNT_W-1:0] B_HALF   = PERIOD - (ON_CYC >> 1);

  reg  [`BMS_LLC_CNT_W-1:0] cnt;
  reg                       running;
  reg                       stopping;
  wire                      at_wrap;

  assign at_wrap = (cnt == PERIOD - 1'b1);
  assign busy    = running;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt      <= {`BMS_LLC_CNT_W{1'b0}};
      running  <= 1'b0;
      stopping <= 1'b0;
      gate_a   <= 1'b0;
      gate_b   <= 1'b0;
    end else if (!running) begin
      gate_a   <= 1'b0;
      gate_b   <= 1'b0;
      stopping <= 1'b0;
      if (enable) begin
        // Start mid-window so the opening pulse on A is half width
        running <= 1'b1;
        cnt     <= A_HALF;
        gate_a  <= 1'b1;
      end
    end else begin
      cnt <= at_wrap ? {`BMS_LLC_CNT_W{1'b0}} : cnt + 1'b1;
      // Stop is taken only at a period start, so A stays full before the last B
      if (at_wrap && !enable) begin
        stopping <= 1'b1;
      end
      if (stopping && (cnt == B_HALF - 1'b1)) begin
        // Closing pulse on B cut to half width
        running <= 1'b0;
        gate_a  <= 1'b0;
        gate_b  <= 1'b0;
      end else begin
        // Same width and 180 degree offset for both outputs
        gate_a <= (at_wrap ? (DEAD_CYC == 0) : (cnt + 1'b1 >= DEAD_CYC) &&
                   (cnt + 1'b1 < HALF_CYC));
        gate_b <= !at_wrap && (cnt + 1'b1 >= HALF_CYC + DEAD_CYC);
      end
    end
  end

endmodule

`default_nettype wire

// *** rtl/bms_sequencer.v ***
// The implementer's own choices: register access over AXI4-Lite and the address map.
`include "bms_consts.vh"
`default_nettype none

// Functional notes
// - Pin low through read time selects aux bias
// - Aux mode mid pin level runs POWER_FACTOR_STAGE only
// - Aux high pin runs both, low stops
// - Pin at rail during read selects self bias
// - Self bias ignores pin as on/off
// - Start-up FET off at start threshold
// - Self bias turns start-up FET back on
// - At self-bias start FET off, gated POWER_FACTOR_STAGE start
// - Self bias runs while rail above stop
// - Undervoltage of active mode stops both stages
// - Aux undervoltage restarts after rail recovers
// - Self-bias undervoltage recharges then restarts sequence
// - Half-width first pulse A, last B
// - Gates complementary, half period apart, under half duty
// - Gate duty cycles matched in steady state
// - Aux start takes about 150 to 250 ms
// - Undervoltage is short fault, 100 ms delay
module bms_sequencer #(
  parameter [`BMS_TMR_W-1:0] MODE_READ_CYC = `BMS_MODE_READ_CYC,
  parameter [`BMS_TMR_W-1:0] START_DLY_CYC = `BMS_START_DLY_CYC,
  parameter [`BMS_TMR_W-1:0] FAULT_DLY_CYC = `BMS_FAULT_DLY_CYC,
  parameter [`BMS_LLC_CNT_W-1:0] LLC_HALF_CYC = `BMS_LLC_HALF_CYC,
  parameter [`BMS_LLC_CNT_W-1:0] LLC_DEAD_CYC = `BMS_LLC_DEAD_CYC
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // Comparator flags
  input  wire        vcc_above_start,
  input  wire        vcc_above_self_bias_start_level,
  input  wire        vcc_above_self_bias_stop_level,
  input  wire        vcc_above_aux_bias_stop_level,
  input  wire        mode_run_pin_above_select,
  input  wire        mode_run_pin_above_pfc_run_level,
  input  wire        mode_run_pin_above_combined_run_level,
  input  wire        mode_run_pin_at_rail,
  input  wire        line_current_above_rising_level,
  input  wire        bus_voltage_above_line_peak,
  // Power stage controls
  output reg         startup_fet_gate,
  output reg         power_factor_stage_run,
  output reg         llc_run,
  output wire        llc_gate_a,
  output wire        llc_gate_b,
  // AXI4-Lite write address
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // AXI4-Lite read address
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);

  localparam [3:0] ST_CHARGE      = 4'h0;
  localparam [3:0] ST_MODE_READ   = 4'h1;
  localparam [3:0] ST_AUX_RUN     = 4'h2;
  localparam [3:0] ST_SB_CHARGE   = 4'h3;
  localparam [3:0] ST_SB_CHECK    = 4'h4;
  localparam [3:0] ST_SB_RUN      = 4'h5;
  localparam [3:0] ST_FAULT_WAIT  = 4'h6;
  localparam [3:0] ST_AUX_RECOVER = 4'h7;

  localparam [1:0] IDX_CONTROL = 2'd0;
  localparam [1:0] IDX_STATUS  = 2'd1;
  localparam [1:0] IDX_NONE    = 2'd3;

  function [1:0] reg_index;
    input [11:0] addr;
    begin
      case (addr)
        `BMS_OFF_CONTROL: reg_index = IDX_CONTROL;
        `BMS_OFF_STATUS:  reg_index = IDX_STATUS;
        default:          reg_index = IDX_NONE;
      endcase
    end
  endfunction

  // Flag synchronisers; only stage two is read
  wire [`BMS_NFLAG-1:0] flag_raw;
  reg  [`BMS_NFLAG-1:0] flag_meta;
  reg  [`BMS_NFLAG-1:0] flag;

  assign flag_raw = {bus_voltage_above_line_peak, line_current_above_rising_level,
                     mode_run_pin_at_rail, mode_run_pin_above_combined_run_level,
                     mode_run_pin_above_pfc_run_level, mode_run_pin_above_select,
                     vcc_above_aux_bias_stop_level, vcc_above_self_bias_stop_level,
                     vcc_above_self_bias_start_level, vcc_above_start};

  always @(posedge aclk) begin
    if (!aresetn) begin
      flag_meta <= {`BMS_NFLAG{1'b0}};
      flag      <= {`BMS_NFLAG{1'b0}};
    end else begin
      flag_meta <= flag_raw;
      flag      <= flag_meta;
    end
  end

  reg [3:0]            state;
  reg [3:0]            next_state;
  reg [`BMS_TMR_W-1:0] tmr;
  reg [`BMS_TMR_W-1:0] next_tmr;
  reg                  self_bias;
  reg                  next_self_bias;
  reg                  decided;
  reg                  next_decided;
  reg                  saw_select;
  reg                  next_saw_select;
  reg                  aux_live;
  reg                  next_aux_live;
  reg                  next_fet;
  reg                  next_pfc;
  reg                  next_llc;
  reg                  uv_event;
  reg                  run_allow;
  reg                  uv_seen;
  wire                 gate_busy;

  always @* begin
    next_state      = state;
    next_tmr        = tmr + 1'b1;
    next_self_bias  = self_bias;
    next_decided    = decided;
    next_saw_select = saw_select;
    next_aux_live   = 1'b0;
    next_fet        = 1'b0;
    next_pfc        = 1'b0;
    next_llc        = 1'b0;
    uv_event        = 1'b0;
    case (state)
      ST_CHARGE: begin
        // Depletion FET charges the rail until the start threshold
        next_fet = 1'b1;
        next_tmr = {`BMS_TMR_W{1'b0}};
        if (flag[`BMS_F_VCC_START]) begin
          next_fet        = 1'b0;
          next_saw_select = 1'b0;
          next_state      = ST_MODE_READ;
        end
      end
      ST_MODE_READ: begin
        if (flag[`BMS_F_MODE_SELECT] || flag[`BMS_F_MODE_RAIL]) begin
          next_saw_select = 1'b1;
        end
        if (tmr == MODE_READ_CYC - 1'b1) begin
          next_tmr     = {`BMS_TMR_W{1'b0}};
          next_decided = 1'b1;
          if (next_saw_select) begin
            next_self_bias = 1'b1;
            next_fet       = 1'b1;
            next_state     = ST_SB_CHARGE;
          end else begin
            next_self_bias = 1'b0;
            next_state     = ST_AUX_RUN;
          end
        end
      end
      ST_AUX_RUN: begin
        if (!flag[`BMS_F_VCC_AB_STOP]) begin
          uv_event   = 1'b1;
          next_tmr   = {`BMS_TMR_W{1'b0}};
          next_state = ST_FAULT_WAIT;
        end else if (!(flag[`BMS_F_PFC_RUN] && run_allow)) begin
          next_tmr = {`BMS_TMR_W{1'b0}};
        end else begin
          // Start delay before stages come
          next_aux_live = aux_live || (tmr == START_DLY_CYC - 1'b1);
          if (next_aux_live) begin
            next_tmr = {`BMS_TMR_W{1'b0}};
          end
          next_pfc = next_aux_live;
          next_llc = next_aux_live && flag[`BMS_F_COMB_RUN];
        end
      end
      ST_SB_CHARGE: begin
        next_fet = 1'b1;
        next_tmr = {`BMS_TMR_W{1'b0}};
        if (flag[`BMS_F_SELF_BIAS_START_LEVEL]) begin
          next_fet   = 1'b0;
          next_state = ST_SB_CHECK;
        end
      end
      ST_SB_CHECK: begin
        next_tmr = {`BMS_TMR_W{1'b0}};
        if (!flag[`BMS_F_SELF_BIAS_STOP_LEVEL]) begin
          uv_event   = 1'b1;
          next_fet   = 1'b1;
          next_state = ST_FAULT_WAIT;
        end else if (flag[`BMS_F_LINE_CUR] && flag[`BMS_F_BUS_OK] && run_allow) begin
          next_pfc   = 1'b1;
          next_state = ST_SB_RUN;
        end
      end
      ST_SB_RUN: begin
        // Mode pin plays no part here
        next_tmr = {`BMS_TMR_W{1'b0}};
        if (!flag[`BMS_F_SELF_BIAS_STOP_LEVEL] || !run_allow) begin
          uv_event   = !flag[`BMS_F_SELF_BIAS_STOP_LEVEL];
          next_fet   = 1'b1;
          next_state = ST_FAULT_WAIT;
        end else begin
          next_pfc = 1'b1;
          next_llc = 1'b1;
        end
      end
      ST_FAULT_WAIT: begin
        // Short fault hold-off; self bias keeps charging meanwhile
        next_fet = self_bias;
        if (tmr == FAULT_DLY_CYC - 1'b1) begin
          next_tmr   = {`BMS_TMR_W{1'b0}};
          next_state = self_bias ? ST_SB_CHARGE : ST_AUX_RECOVER;
        end
      end
      ST_AUX_RECOVER: begin
        next_tmr = {`BMS_TMR_W{1'b0}};
        if (flag[`BMS_F_VCC_AB_STOP]) begin
          next_state = ST_AUX_RUN;
        end
      end
      default: begin
        next_tmr   = {`BMS_TMR_W{1'b0}};
        next_fet   = 1'b1;
        next_state = ST_CHARGE;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      state                  <= ST_CHARGE;
      tmr                    <= {`BMS_TMR_W{1'b0}};
      self_bias              <= 1'b0;
      decided                <= 1'b0;
      saw_select             <= 1'b0;
      aux_live               <= 1'b0;
      startup_fet_gate       <= 1'b1;
      power_factor_stage_run <= 1'b0;
      llc_run                <= 1'b0;
    end else begin
      state                  <= next_state;
      tmr                    <= next_tmr;
      // Mode is fixed until the next power-up
      self_bias              <= decided ? self_bias : next_self_bias;
      decided                <= next_decided;
      saw_select             <= next_saw_select;
      aux_live               <= next_aux_live;
      startup_fet_gate       <= next_fet;
      power_factor_stage_run <= next_pfc;
      llc_run                <= next_llc;
    end
  end

  bms_gate_gen #(
    .HALF_CYC (LLC_HALF_CYC),
    .DEAD_CYC (LLC_DEAD_CYC)
  ) u_gate (
    .aclk    (aclk),
    .aresetn (aresetn),
    .enable  (llc_run),
    .gate_a  (llc_gate_a),
    .gate_b  (llc_gate_b),
    .busy    (gate_busy)
  );

  // AXI4-Lite slave; address and data taken in either order
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  wire        aw_take;
  wire        w_take;
  wire        ar_take;
  wire        wr_fire;
  wire [1:0]  wr_idx;
  wire [1:0]  rd_idx;
  wire [31:0] status_word;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
  assign wr_idx        = reg_index(aw_addr);
  assign rd_idx        = reg_index(s_axi_araddr);
  assign status_word   = {22'h00_0000, uv_seen, startup_fet_gate, gate_busy,
                          power_factor_stage_run, decided, self_bias, state};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held      <= 1'b0;
      w_held       <= 1'b0;
      aw_addr      <= 12'h000;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `BMS_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= `BMS_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      run_allow    <= `BMS_CTL_RESET;
      uv_seen      <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_idx == IDX_NONE) ? `BMS_RESP_SLVERR : `BMS_RESP_OKAY;
        if (wr_idx == IDX_CONTROL && w_strb[0]) begin
          run_allow <= w_data[`BMS_CTL_RUN_ALLOW];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      // Set beats write-one-to-clear in the same cycle
      if (uv_event) begin
        uv_seen <= 1'b1;
      end else if (wr_fire && wr_idx == IDX_STATUS && w_strb[1] &&
                   w_data[`BMS_ST_UV_SEEN]) begin
        uv_seen <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        case (rd_idx)
          IDX_CONTROL: begin
            s_axi_rdata <= {31'h0000_0000, run_allow};
            s_axi_rresp <= `BMS_RESP_OKAY;
          end
          IDX_STATUS: begin
            s_axi_rdata <= status_word;
            s_axi_rresp <= `BMS_RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `BMS_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/bms_sequencer_monitor.sv ***
`include "bms_consts.vh"
`default_nettype none
module bms_sequencer_monitor #(
  parameter [`BMS_LLC_CNT_W-1:0] LLC_HALF_CYC = `BMS_LLC_HALF_CYC,
  parameter [`BMS_LLC_CNT_W-1:0] LLC_DEAD_CYC = `BMS_LLC_DEAD_CYC
) (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Rail flags
  input wire logic        vcc_above_start,
  input wire logic        vcc_above_self_bias_stop_level,
  input wire logic        vcc_above_aux_bias_stop_level,
  // Stage outputs
  input wire logic        startup_fet_gate,
  input wire logic        power_factor_stage_run,
  input wire logic        llc_run,
  input wire logic        llc_gate_a,
  input wire logic        llc_gate_b,
  // AXI answers
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam [15:0] FULL = LLC_HALF_CYC - LLC_DEAD_CYC;
  localparam int    DGAP = LLC_DEAD_CYC;
  logic [15:0] cnt_a;
  logic [15:0] cnt_b;
  logic        start_seen;
  // Only the first start crossing turns the FET off; later ones are recharges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_a      <= 16'h0000;
      cnt_b      <= 16'h0000;
      start_seen <= 1'b0;
    end else begin
      cnt_a      <= llc_gate_a ? cnt_a + 16'h0001 : 16'h0000;
      cnt_b      <= llc_gate_b ? cnt_b + 16'h0001 : 16'h0000;
      start_seen <= start_seen | vcc_above_start;
    end
  end
  default clocking mon_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  AST_FET_OFF_AT_START: assert property (
    $rose(vcc_above_start) && !start_seen |-> ##[1:5] !startup_fet_gate)
    else $error("start-up FET not off after start crossing");
  AST_UV_STOPS: assert property (
    (!vcc_above_aux_bias_stop_level && !vcc_above_self_bias_stop_level) [*6]
    |-> !power_factor_stage_run && !llc_run)
    else $error("stages still on under rail undervoltage");
  AST_LLC_NEEDS_PFC: assert property (
    llc_run |-> power_factor_stage_run)
    else $error("resonant stage on without POWER_FACTOR_STAGE stage");
  AST_GATES_EXCL: assert property (
    !(llc_gate_a && llc_gate_b))
    else $error("both gate outputs high");
  AST_WIDTH_A: assert property (
    $fell(llc_gate_a) |-> (cnt_a == FULL) || (cnt_a == (FULL >> 1)))
    else $error("gate A pulse width wrong");
  AST_WIDTH_B: assert property (
    $fell(llc_gate_b) |-> (cnt_b == FULL) || (cnt_b == (FULL >> 1)))
    else $error("gate B pulse width wrong");
  AST_BURST_OPENS_A: assert property (
    $rose(llc_run) |-> ##[1:3] llc_gate_a)
    else $error("burst does not open on gate A");
  AST_HALF_PERIOD: assert property (
    $fell(llc_gate_a) && cnt_a == FULL |-> ##DGAP $rose(llc_gate_b))
    else $error("gate B not half a period after gate A");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_R_RELEASE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  AST_B_RELEASE: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  cover property (power_factor_stage_run && !llc_run);
  cover property ($fell(llc_gate_b) && cnt_b == (FULL >> 1));
  cover property (s_axi_bvalid && s_axi_bresp == `BMS_RESP_SLVERR);
endmodule
bind bms_sequencer bms_sequencer_monitor #(
  .LLC_HALF_CYC(LLC_HALF_CYC), .LLC_DEAD_CYC(LLC_DEAD_CYC)
) bms_sequencer_monitor_inst (
  .aclk(aclk), .aresetn(aresetn), .vcc_above_start(vcc_above_start),
  .vcc_above_self_bias_stop_level(vcc_above_self_bias_stop_level),
  .vcc_above_aux_bias_stop_level(vcc_above_aux_bias_stop_level),
  .startup_fet_gate(startup_fet_gate), .power_factor_stage_run(power_factor_stage_run),
  .llc_run(llc_run), .llc_gate_a(llc_gate_a), .llc_gate_b(llc_gate_b),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp)
);
`default_nettype wire

// *** tb/bms_supervisor_model.sv ***
`default_nettype none
module bms_supervisor_model (
  // Clock
  input  wire logic       aclk,
  // Level request: 0 low, 1 POWER_FACTOR_STAGE run, 2 combined run, 3 at rail
  input  wire logic [1:0] cmd,
  input  wire logic [3:0] ramp,
  // Pin comparator flags
  output wire logic       above_select,
  output wire logic       above_pfc,
  output wire logic       above_comb,
  output wire logic       at_rail
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] lvl = 2'h0;
  logic [3:0] cnt = 4'h0;
  // One level per ramp period, like an RC; the pin stays low until
  // asked, so it sits under select through the read
  always @(posedge aclk) begin
    if (lvl == cmd) begin
      cnt <= 4'h0;
    end else if (cnt >= ramp) begin
      cnt <= 4'h0;
      lvl <= (cmd > lvl) ? lvl + 2'h1 : lvl - 2'h1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  assign above_select = (lvl != 2'h0);
  assign above_pfc    = (lvl != 2'h0);
  assign above_comb   = (lvl >= 2'h2);
  assign at_rail      = (lvl == 2'h3);
endmodule
`default_nettype wire

// *** tb/test_bms_sequencer.sv ***
`default_nettype none
module test_bms_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MRD = 20;
  localparam int SDL = 30;
  localparam int FDL = 25;
  logic aclk, aresetn, v_start, v_sbs, v_sbp, v_abp, l_cur, b_ok;
  logic p_sel, p_pfc, p_comb, p_rail, fet, power_factor_stage, llc, ga, gb;
  logic [1:0] pin_cmd;
  logic [3:0] ramp;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int err_total = 0;
  int num_checks = 0;
  bms_supervisor_model bms_supervisor_model_inst (
    .aclk(aclk), .cmd(pin_cmd), .ramp(ramp), .above_select(p_sel),
    .above_pfc(p_pfc), .above_comb(p_comb), .at_rail(p_rail));
  bms_sequencer #(.MODE_READ_CYC(24'h0014), .START_DLY_CYC(24'h001e),
    .FAULT_DLY_CYC(24'h0019), .LLC_HALF_CYC(16'h0014), .LLC_DEAD_CYC(16'h0004)
  ) bms_sequencer_inst (
    .aclk(aclk), .aresetn(aresetn), .vcc_above_start(v_start),
    .vcc_above_self_bias_start_level(v_sbs), .vcc_above_self_bias_stop_level(v_sbp),
    .vcc_above_aux_bias_stop_level(v_abp), .mode_run_pin_above_select(p_sel),
    .mode_run_pin_above_pfc_run_level(p_pfc), .mode_run_pin_above_combined_run_level(p_comb),
    .mode_run_pin_at_rail(p_rail), .line_current_above_rising_level(l_cur),
    .bus_voltage_above_line_peak(b_ok), .startup_fet_gate(fet),
    .power_factor_stage_run(power_factor_stage), .llc_run(llc), .llc_gate_a(ga), .llc_gate_b(gb),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    begin
      num_checks++;
      if (seen !== exp) begin
        err_total++;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task tmo;
    begin
      err_total++;
      $display("unexpected timeout at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
      end_of_test;
    end
  endtask
  // Bounded wait for one output; n gives the edges taken
  task wait_out(input int sel, input logic v, input int lim, output int n);
    logic s;
    begin
      n = 0;
      s = ~v;
      while (s !== v) begin
        @(posedge aclk);
        n++;
        case (sel)
          0: s = fet;
          1: s = power_factor_stage;
          2: s = llc;
          default: s = gb;
        endcase
        if (n > lim) tmo;
      end
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
          input logic [1:0] er);
    int n;
    begin
      n = 0;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 50);
      if (s_axi_bvalid !== 1'b1) tmo;
      chk(s_axi_bresp, er);
    end
  endtask
  task rd(input logic [11:0] a, input logic [1:0] er, output logic [31:0] d);
    int n;
    begin
      n = 0;
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      if (s_axi_rvalid !== 1'b1) tmo;
      d = s_axi_rdata;
      chk(s_axi_rresp, er);
    end
  endtask
  initial begin
    int c;
    int c2;
    logic [31:0] d;
    {aresetn, v_start, v_sbs, v_sbp, v_abp, l_cur, b_ok} = 7'h00;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    pin_cmd = 2'h0;
    ramp = 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({fet, power_factor_stage, llc, ga, gb}, 32'h0000_0010);
    rd(12'h000, 2'h0, d);
    chk(d, 32'h0000_0001);
    rd(12'h004, 2'h0, d);
    chk(d, 32'h0000_0100);
    rd(12'h008, 2'h2, d);
    chk(d, 32'h0000_0000);
    wr(12'h00c, 32'h0000_0000, 4'hf, 2'h2);
    $display("test reset done");
    v_start <= 1'b1;
    v_abp   <= 1'b1;
    wait_out(0, 1'b0, 8, c);
    repeat (MRD + 8) @(posedge aclk);
    rd(12'h004, 2'h0, d);
    chk(d, 32'h0000_0022);
    pin_cmd <= 2'h1;
    wait_out(1, 1'b1, SDL + 20, c);
    chk(c >= SDL && c <= SDL + 10, 32'h1);
    chk(llc, 32'h0);
    pin_cmd <= 2'h2;
    wait_out(2, 1'b1, 12, c);
    wait_out(3, 1'b1, 80, c);
    ramp    <= 4'h3;
    pin_cmd <= 2'h0;
    wait_out(1, 1'b0, 20, c);
    chk(llc, 32'h0);
    wr(12'h000, 32'h0000_0000, 4'h1, 2'h0);
    pin_cmd <= 2'h2;
    repeat (SDL + 20) @(posedge aclk);
    chk(power_factor_stage, 32'h0);
    wr(12'h000, 32'h0000_0001, 4'h1, 2'h0);
    wait_out(2, 1'b1, SDL + 20, c);
    $display("test aux run done");
    pin_cmd <= 2'h1;
    repeat (100) @(posedge aclk);
    v_abp <= 1'b0;
    wait_out(1, 1'b0, 8, c);
    repeat (4) @(posedge aclk);
    v_abp <= 1'b1;
    wait_out(1, 1'b1, FDL + SDL + 30, c2);
    chk(c + 4 + c2 >= FDL + SDL, 32'h1);
    rd(12'h004, 2'h0, d);
    chk(d & 32'h0000_0200, 32'h0000_0200);
    wr(12'h004, 32'h0000_0200, 4'h2, 2'h0);
    rd(12'h004, 2'h0, d);
    chk(d & 32'h0000_0200, 32'h0000_0000);
    $display("test aux fault done");
    {aresetn, v_start, v_abp} <= 3'h0;
    pin_cmd <= 2'h3;
    ramp    <= 4'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    v_start <= 1'b1;
    wait_out(0, 1'b0, 8, c);
    wait_out(0, 1'b1, MRD + 10, c);
    rd(12'h004, 2'h0, d);
    chk(d & 32'h0000_0030, 32'h0000_0030);
    {v_sbs, v_sbp} <= 2'h3;
    wait_out(0, 1'b0, 8, c);
    repeat (20) @(posedge aclk);
    chk(power_factor_stage, 32'h0);
    {l_cur, b_ok} <= 2'h3;
    wait_out(2, 1'b1, 12, c);
    pin_cmd <= 2'h0;
    repeat (20) @(posedge aclk);
    chk({power_factor_stage, llc}, 32'h3);
    {v_sbs, v_sbp} <= 2'h0;
    wait_out(1, 1'b0, 8, c);
    wait_out(0, 1'b1, FDL + 10, c);
    repeat (80) @(posedge aclk);
    {v_sbs, v_sbp} <= 2'h3;
    wait_out(0, 1'b0, 8, c);
    wait_out(2, 1'b1, 12, c);
    $display("test self bias done");
    end_of_test;
  end
endmodule
`default_nettype wire
